// [rtl/mlcs_pkg.sv]
// Package for the modem line control and status block.
// Assumes one system clock and a synchronous active-low bus initialize.
package mlcs_pkg;

  localparam int NUM_LINES     = 16;
  localparam int LINE_W        = 4;
  localparam int CTRL_W        = 4;
  localparam int STAT_W        = 4;
  localparam int REG_W         = 8;
  localparam int SEC_REGS      = 16;
  localparam int SEC_ADDR_W    = 4;
  localparam int SEC_DATA_W    = 16;

  // Field positions in line_modem_register
  localparam int BIT_LINE_EN   = 0;
  localparam int BIT_TERM_RDY  = 1;
  localparam int BIT_RTS       = 2;
  localparam int BIT_NS_SECTX  = 3;
  localparam int BIT_STAT_LO   = 4;
  localparam int BIT_DSR_SECRX = 4;
  localparam int BIT_CTS       = 5;
  localparam int BIT_CARRIER   = 6;
  localparam int BIT_RING      = 7;

  // Index into the per-line status nibble
  localparam int ST_DSR_SECRX  = 0;
  localparam int ST_CTS        = 1;
  localparam int ST_CARRIER    = 2;
  localparam int ST_RING       = 3;

  localparam logic [CTRL_W-1:0]     CTRL_RESET   = 4'h0;
  localparam logic [STAT_W-1:0]     STAT_RESET   = 4'h0;
  localparam logic [LINE_W-1:0]     LINE_RESET   = 4'h0;
  localparam logic [SEC_ADDR_W-1:0] SEC_RESET    = 4'h0;
  localparam logic [REG_W-1:0]      RD_RESET     = 8'h00;
  localparam logic [SEC_DATA_W-1:0] SEC_RD_RESET = 16'h0000;

  typedef enum logic [1:0] {
    MLCS_SCAN_IDLE,
    MLCS_SCAN_RUN,
    MLCS_SCAN_HALT
  } mlcs_scan_state_t;

endpackage : mlcs_pkg

// [rtl/mlcs_line_bank.sv]
// Per-line modem control bits and the registered modem control outputs.
// Assumes write strobes come from logic on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module mlcs_line_bank #(
  parameter int LINES = mlcs_pkg::NUM_LINES
) (
  input  wire logic                                 sys_clk,
  input  wire logic                                 rst_n,
  input  wire logic                                 clear_all,
  input  wire logic                                 wr_en,
  input  wire logic [mlcs_pkg::LINE_W-1:0]          wr_line,
  input  wire logic [mlcs_pkg::CTRL_W-1:0]          wr_data,
  input  wire logic                                 sync_mode,
  output logic [LINES-1:0][mlcs_pkg::CTRL_W-1:0]    ctrl_bits,
  output logic [LINES-1:0]                          terminal_ready,
  output logic [LINES-1:0]                          request_to_send,
  output logic [LINES-1:0]                          new_sync,
  output logic [LINES-1:0]                          secondary_transmit
);

  for (genvar i = 0; i < LINES; i++) begin : g_line
    always_ff @(posedge sys_clk) begin
      if (!rst_n || clear_all) begin
        ctrl_bits[i] <= mlcs_pkg::CTRL_RESET;
      end else if (wr_en && wr_line == mlcs_pkg::LINE_W'(i)) begin
        ctrl_bits[i] <= wr_data;
      end
    end

    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        terminal_ready[i]     <= 1'b0;
        request_to_send[i]    <= 1'b0;
        new_sync[i]           <= 1'b0;
        secondary_transmit[i] <= 1'b0;
      end else begin
        terminal_ready[i]  <= ctrl_bits[i][mlcs_pkg::BIT_TERM_RDY];
        request_to_send[i] <= ctrl_bits[i][mlcs_pkg::BIT_RTS];
        // Bit 3 means different pins in the two configurations
        new_sync[i] <= ctrl_bits[i][mlcs_pkg::BIT_NS_SECTX]
                       & sync_mode;
        secondary_transmit[i] <= ctrl_bits[i][mlcs_pkg::BIT_NS_SECTX]
                                 & ~sync_mode;
      end
    end
  end

endmodule : mlcs_line_bank
`default_nettype wire

// [rtl/mlcs_sec_ram.sv]
// Secondary register RAM, 16 words for each line, two read ports.
// Deliberately no reset: contents survive bus initialize.
`timescale 1ns/1ps
`default_nettype none
module mlcs_sec_ram #(
  parameter int LINES  = mlcs_pkg::NUM_LINES,
  parameter int REGS   = mlcs_pkg::SEC_REGS,
  parameter int DATA_W = mlcs_pkg::SEC_DATA_W
) (
  input  wire logic                              sys_clk,
  input  wire logic                              wr_en,
  input  wire logic [mlcs_pkg::LINE_W-1:0]       wr_line,
  input  wire logic [mlcs_pkg::SEC_ADDR_W-1:0]   wr_reg,
  input  wire logic [DATA_W-1:0]                 wr_data,
  input  wire logic [mlcs_pkg::LINE_W-1:0]       rd_a_line,
  input  wire logic [mlcs_pkg::SEC_ADDR_W-1:0]   rd_a_reg,
  output logic [DATA_W-1:0]                      rd_a_data,
  input  wire logic [mlcs_pkg::LINE_W-1:0]       rd_b_line,
  input  wire logic [mlcs_pkg::SEC_ADDR_W-1:0]   rd_b_reg,
  output logic [DATA_W-1:0]                      rd_b_data
);

  logic [DATA_W-1:0] mem [LINES*REGS];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[{wr_line, wr_reg}] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    rd_a_data <= mem[{rd_a_line, rd_a_reg}];
    rd_b_data <= mem[{rd_b_line, rd_b_reg}];
  end

endmodule : mlcs_sec_ram
`default_nettype wire

// [rtl/mlcs_top.sv]
// Modem line control/status register and secondary register access.
// Assumes line select and strobes come from sys_clk logic; modem
// status pins and the mode strap are asynchronous and synchronised here.
//
// Summary of operation
// - With line enable set, selected modem status shows in bits 4-7.
// - Status change on an enabled line (ring only as it comes on) sets scan done while scanning.
// - Control bits 0-3 of all lines clear on initialize and clear-all.
// - Bit 1 set holds terminal ready asserted for that line.
// - Bit 2 set asserts request to send for that line.
// - Synchronous configuration: bit 3 drives new sync.
// - Asynchronous configuration: bit 3 drives secondary transmit.
// - Sync mode: bit 4 reads data set ready when line enabled.
// - Async mode: bit 4 reads secondary receive when line enabled.
// - Bit 5 reads clear to send when line enabled.
// - Bit 6 reads carrier detect when line enabled.
// - Bit 7 reads ring when line enabled.
// - Sixteen secondary registers per line, 256 total, held in RAM.
// - Host reaches secondary registers via select and address registers; processor port addresses them directly.
// - Clear-all clears every line at once and reads back zero.
// - Initialize does not clear secondary registers.
`timescale 1ns/1ps
`default_nettype none
module mlcs_top #(
  parameter int LINES = mlcs_pkg::NUM_LINES
) (
  input  wire logic                                  sys_clk,
  input  wire logic                                  rst_n,
  // Main control register fields this block depends on
  input  wire logic [mlcs_pkg::LINE_W-1:0]           line_select,
  input  wire logic                                  clear_all_lines,
  input  wire logic                                  scan_enable,
  input  wire logic                                  scan_clear,
  input  wire logic                                  done_clear,
  output logic                                       scan_done_set,
  output logic [mlcs_pkg::LINE_W-1:0]                scan_line,
  output logic [mlcs_pkg::STAT_W-1:0]                scan_transitions,
  // line_modem_register access
  input  wire logic                                  lmr_wr_en,
  input  wire logic [mlcs_pkg::REG_W-1:0]            lmr_wr_data,
  output logic [mlcs_pkg::REG_W-1:0]                 lmr_rd_data,
  // Configuration strap: 1 = synchronous modems
  input  wire logic                                  sync_mode_pin,
  // Modem status pins, one bit per line
  input  wire logic [LINES-1:0]                      modem_dsr_secondary_receive,
  input  wire logic [LINES-1:0]                      modem_cts,
  input  wire logic [LINES-1:0]                      modem_carrier,
  input  wire logic [LINES-1:0]                      modem_ring,
  // Modem control outputs
  output logic [LINES-1:0]                           terminal_ready,
  output logic [LINES-1:0]                           request_to_send,
  output logic [LINES-1:0]                           new_sync,
  output logic [LINES-1:0]                           secondary_transmit,
  // Host indirect access to secondary registers
  input  wire logic                                  sec_select_wr,
  input  wire logic                                  sec_address_wr,
  input  wire logic [mlcs_pkg::LINE_W-1:0]           sec_index_data,
  input  wire logic                                  sec_data_wr,
  input  wire logic [mlcs_pkg::SEC_DATA_W-1:0]       sec_wr_data,
  output logic [mlcs_pkg::SEC_DATA_W-1:0]            sec_rd_data,
  output logic [mlcs_pkg::LINE_W-1:0]                secondary_select,
  output logic [mlcs_pkg::SEC_ADDR_W-1:0]            secondary_address,
  // Internal processor port to the same RAM
  input  wire logic                                  dev_wr_en,
  output logic                                       dev_wr_grant,
  input  wire logic [mlcs_pkg::LINE_W-1:0]           dev_line,
  input  wire logic [mlcs_pkg::SEC_ADDR_W-1:0]       dev_reg,
  input  wire logic [mlcs_pkg::SEC_DATA_W-1:0]       dev_wr_data,
  output logic [mlcs_pkg::SEC_DATA_W-1:0]            dev_rd_data
);

  // Synchronisers
  logic [LINES-1:0] dsr_s1_q, dsr_s2_q;
  logic [LINES-1:0] cts_s1_q, cts_s2_q;
  logic [LINES-1:0] car_s1_q, car_s2_q;
  logic [LINES-1:0] ring_s1_q, ring_s2_q;
  logic             mode_s1_q, mode_s2_q;
  logic             sync_mode_q;

  always_ff @(posedge sys_clk) begin
    dsr_s1_q  <= modem_dsr_secondary_receive;
    dsr_s2_q  <= dsr_s1_q;
    cts_s1_q  <= modem_cts;
    cts_s2_q  <= cts_s1_q;
    car_s1_q  <= modem_carrier;
    car_s2_q  <= car_s1_q;
    ring_s1_q <= modem_ring;
    ring_s2_q <= ring_s1_q;
  end

  always_ff @(posedge sys_clk) begin
    mode_s1_q <= sync_mode_pin;
    mode_s2_q <= mode_s1_q;
  end

  // Strap is followed every cycle after reset release; under reset the mode reads asynchronous
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync_mode_q <= 1'b0;
    end else begin
      sync_mode_q <= mode_s2_q;
    end
  end

  // Control bits
  logic [LINES-1:0][mlcs_pkg::CTRL_W-1:0] ctrl_bits;
  logic [LINES-1:0]                       line_en;

  mlcs_line_bank #(
    .LINES (LINES)
  ) u_line_bank (
    .sys_clk            (sys_clk),
    .rst_n              (rst_n),
    .clear_all          (clear_all_lines),
    .wr_en              (lmr_wr_en),
    .wr_line            (line_select),
    // Upper nibble is read-only and never stored
    .wr_data            (lmr_wr_data[mlcs_pkg::CTRL_W-1:0]),
    .sync_mode          (sync_mode_q),
    .ctrl_bits          (ctrl_bits),
    .terminal_ready     (terminal_ready),
    .request_to_send    (request_to_send),
    .new_sync           (new_sync),
    .secondary_transmit (secondary_transmit)
  );

  // Per-line status nibble, raw and gated by line enable
  logic [LINES-1:0][mlcs_pkg::STAT_W-1:0] stat_raw;
  logic [LINES-1:0][mlcs_pkg::STAT_W-1:0] stat_gated;

  for (genvar i = 0; i < LINES; i++) begin : g_stat
    assign line_en[i] = ctrl_bits[i][mlcs_pkg::BIT_LINE_EN];
    // Same pin carries data set ready or secondary receive per mode
    assign stat_raw[i][mlcs_pkg::ST_DSR_SECRX] = dsr_s2_q[i];
    assign stat_raw[i][mlcs_pkg::ST_CTS]       = cts_s2_q[i];
    assign stat_raw[i][mlcs_pkg::ST_CARRIER]   = car_s2_q[i];
    assign stat_raw[i][mlcs_pkg::ST_RING]      = ring_s2_q[i];
    assign stat_gated[i] = line_en[i] ? stat_raw[i]
                                      : mlcs_pkg::STAT_RESET;
  end

  // Register read: status in the high nibble, control in the low
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lmr_rd_data <= mlcs_pkg::RD_RESET;
    end else begin
      lmr_rd_data <= {stat_gated[line_select],
                      ctrl_bits[line_select]};
    end
  end

  // Scanner: walks lines, compares against scan memory
  mlcs_pkg::mlcs_scan_state_t             scan_state_q;
  logic [mlcs_pkg::LINE_W-1:0]            scan_idx_q;
  logic [LINES-1:0][mlcs_pkg::STAT_W-1:0] scan_mem_q;
  logic [mlcs_pkg::STAT_W-1:0]            cur_stat;
  logic [mlcs_pkg::STAT_W-1:0]            prev_stat;
  logic [mlcs_pkg::STAT_W-1:0]            trans;
  logic                                   scan_run;
  logic                                   scan_hit;

  assign cur_stat  = stat_raw[scan_idx_q];
  assign prev_stat = scan_mem_q[scan_idx_q];
  assign scan_run  = scan_state_q == mlcs_pkg::MLCS_SCAN_RUN;

  always_comb begin
    trans = cur_stat ^ prev_stat;
    // Ring counts only as it comes on
    trans[mlcs_pkg::ST_RING] = cur_stat[mlcs_pkg::ST_RING]
                               & ~prev_stat[mlcs_pkg::ST_RING];
  end

  assign scan_hit = scan_run && line_en[scan_idx_q]
                    && (trans != mlcs_pkg::STAT_RESET);

  always_ff @(posedge sys_clk) begin
    if (!rst_n || scan_clear) begin
      scan_state_q <= mlcs_pkg::MLCS_SCAN_IDLE;
    end else begin
      case (scan_state_q)
        mlcs_pkg::MLCS_SCAN_IDLE: begin
          if (scan_enable) begin
            scan_state_q <= mlcs_pkg::MLCS_SCAN_RUN;
          end
        end
        mlcs_pkg::MLCS_SCAN_RUN: begin
          if (scan_hit) begin
            scan_state_q <= mlcs_pkg::MLCS_SCAN_HALT;
          end else if (!scan_enable) begin
            scan_state_q <= mlcs_pkg::MLCS_SCAN_IDLE;
          end
        end
        mlcs_pkg::MLCS_SCAN_HALT: begin
          if (done_clear) begin
            scan_state_q <= scan_enable ? mlcs_pkg::MLCS_SCAN_RUN
                                        : mlcs_pkg::MLCS_SCAN_IDLE;
          end
        end
        default: begin
          scan_state_q <= mlcs_pkg::MLCS_SCAN_IDLE;
        end
      endcase
    end
  end

  // Index holds on a hit so the reported line stays put
  always_ff @(posedge sys_clk) begin
    if (!rst_n || scan_clear) begin
      scan_idx_q <= mlcs_pkg::LINE_RESET;
    end else if (scan_run && !scan_hit) begin
      // Wrap at LINES-1
      if (scan_idx_q == mlcs_pkg::LINE_W'(LINES - 1)) begin
        scan_idx_q <= mlcs_pkg::LINE_RESET;
      end else begin
        scan_idx_q <= scan_idx_q + 1'b1;
      end
    end
  end

  // Cleared memory makes every ON input look like a new transition
  always_ff @(posedge sys_clk) begin
    if (!rst_n || scan_clear) begin
      scan_mem_q <= '0;
    end else if (scan_run) begin
      scan_mem_q[scan_idx_q] <= cur_stat;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || scan_clear) begin
      scan_done_set <= 1'b0;
    end else begin
      scan_done_set <= scan_hit;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || scan_clear) begin
      scan_line        <= mlcs_pkg::LINE_RESET;
      scan_transitions <= mlcs_pkg::STAT_RESET;
    end else begin
      if (scan_hit) begin
        scan_line        <= scan_idx_q;
        scan_transitions <= trans;
      end
    end
  end

  // Indirect secondary access: select and address, then data
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      secondary_select <= mlcs_pkg::LINE_RESET;
    end else if (sec_select_wr) begin
      secondary_select <= sec_index_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      secondary_address <= mlcs_pkg::SEC_RESET;
    end else if (sec_address_wr) begin
      secondary_address <= sec_index_data;
    end
  end

  // Host write wins; the processor retries when not granted
  logic                                  ram_wr_en;
  logic [mlcs_pkg::LINE_W-1:0]           ram_wr_line;
  logic [mlcs_pkg::SEC_ADDR_W-1:0]       ram_wr_reg;
  logic [mlcs_pkg::SEC_DATA_W-1:0]       ram_wr_data;

  assign dev_wr_grant = dev_wr_en && !sec_data_wr;
  assign ram_wr_en    = sec_data_wr || dev_wr_en;
  assign ram_wr_line  = sec_data_wr ? secondary_select  : dev_line;
  assign ram_wr_reg   = sec_data_wr ? secondary_address : dev_reg;
  assign ram_wr_data  = sec_data_wr ? sec_wr_data       : dev_wr_data;

  mlcs_sec_ram #(
    .LINES  (LINES),
    .REGS   (mlcs_pkg::SEC_REGS),
    .DATA_W (mlcs_pkg::SEC_DATA_W)
  ) u_sec_ram (
    .sys_clk   (sys_clk),
    .wr_en     (ram_wr_en),
    .wr_line   (ram_wr_line),
    .wr_reg    (ram_wr_reg),
    .wr_data   (ram_wr_data),
    .rd_a_line (secondary_select),
    .rd_a_reg  (secondary_address),
    .rd_a_data (sec_rd_data),
    .rd_b_line (dev_line),
    .rd_b_reg  (dev_reg),
    .rd_b_data (dev_rd_data)
  );

endmodule : mlcs_top
`default_nettype wire

// [verification/mlcs_props.sv]
// Checker for the modem line control block, bound to mlcs_top.
// Assumes one clock and that no write is issued while reset is low.
`timescale 1ns/1ps
`default_nettype none
module mlcs_props #(
  parameter int LINES = 16
) (
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic [3:0]        line_select,
  input wire logic              clear_all_lines,
  input wire logic              lmr_wr_en,
  input wire logic [7:0]        lmr_wr_data,
  input wire logic [7:0]        lmr_rd_data,
  input wire logic [LINES-1:0]  terminal_ready,
  input wire logic [LINES-1:0]  request_to_send,
  input wire logic [LINES-1:0]  new_sync,
  input wire logic [LINES-1:0]  secondary_transmit,
  input wire logic              scan_done_set,
  input wire logic [3:0]        scan_transitions,
  input wire logic              sec_select_wr,
  input wire logic              sec_address_wr,
  input wire logic              sec_data_wr,
  input wire logic [15:0]       sec_wr_data,
  input wire logic [15:0]       sec_rd_data,
  input wire logic              dev_wr_en,
  input wire logic              dev_wr_grant
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_ready_follows_write: assert property (
    (lmr_wr_en && !clear_all_lines) |-> ##2 terminal_ready[$past(line_select, 2)]
      == $past(lmr_wr_data[1], 2)) else $error("terminal ready wrong");
  a_rts_follows_write: assert property (
    (lmr_wr_en && !clear_all_lines) |-> ##2 request_to_send[$past(line_select, 2)]
      == $past(lmr_wr_data[2], 2)) else $error("request to send wrong");
  a_bit3_one_output: assert property (
    (lmr_wr_en && !clear_all_lines) |-> ##2 (new_sync[$past(line_select, 2)]
      ^ secondary_transmit[$past(line_select, 2)]) == $past(lmr_wr_data[3], 2))
    else $error("bit 3 output wrong");
  a_clear_all_lines: assert property (
    clear_all_lines |-> ##2 (terminal_ready == '0 && request_to_send == '0 &&
      new_sync == '0 && secondary_transmit == '0 && lmr_rd_data[3:0] == 4'h0))
    else $error("clear all left bits set");
  a_status_gated: assert property (
    (lmr_rd_data[7:4] != 4'h0) |-> lmr_rd_data[0])
    else $error("status shown on disabled line");
  a_ctrl_readback: assert property (
    (lmr_wr_en && !clear_all_lines) ##1 (!lmr_wr_en && !clear_all_lines &&
      line_select == $past(line_select)) |=>
      lmr_rd_data[3:0] == $past(lmr_wr_data[3:0], 2))
    else $error("control bits read back wrong");
  a_done_one_cycle: assert property (
    scan_done_set |=> !scan_done_set) else $error("done pulse too long");
  a_done_has_cause: assert property (
    scan_done_set |-> scan_transitions != 4'h0) else $error("done without change");
  a_sec_readback: assert property (
    (sec_data_wr && !sec_select_wr && !sec_address_wr) ##1
      (!sec_data_wr && !sec_select_wr && !sec_address_wr) |=>
      sec_rd_data == $past(sec_wr_data, 2)) else $error("secondary read wrong");
  a_host_priority: assert property (
    dev_wr_grant == (dev_wr_en && !sec_data_wr)) else $error("grant wrong");
endmodule : mlcs_props
`default_nettype wire

// [verification/mlcs_modem_model.sv]
// Modems on all lines: data set ready follows terminal ready, clear to
// send answers request to send DELAY cycles late, others on command.
`timescale 1ns/1ps
`default_nettype none
module mlcs_modem_model #(
  parameter int LINES = 16,
  parameter int DELAY = 4
) (
  input  wire logic             sys_clk,
  input  wire logic [LINES-1:0] terminal_ready,
  input  wire logic [LINES-1:0] request_to_send,
  input  wire logic [LINES-1:0] carrier_cmd,
  input  wire logic [LINES-1:0] ring_cmd,
  output logic      [LINES-1:0] modem_dsr_secondary_receive,
  output logic      [LINES-1:0] modem_cts,
  output logic      [LINES-1:0] modem_carrier,
  output logic      [LINES-1:0] modem_ring
);
  logic [DELAY-1:0][LINES-1:0] cts_pipe_q = '0;
  // Turnaround lag, so a reader never gets the answer for free
  always @(posedge sys_clk) cts_pipe_q <= {cts_pipe_q[DELAY-2:0], request_to_send};
  assign modem_cts        = cts_pipe_q[DELAY-1];
  assign modem_dsr_secondary_receive = terminal_ready;
  assign modem_carrier    = carrier_cmd;
  assign modem_ring       = ring_cmd;
endmodule : mlcs_modem_model
`default_nettype wire

// [verification/test_mlcs_top.sv]
// Self-checking bench for mlcs_top with the modem model on its pins.
// Assumes the checker and modem model files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_mlcs_top;
  logic        sys_clk = 1'b0, rst_n = 1'b0, sync_mode_pin = 1'b1;
  logic [3:0]  line_select = 4'h0, sec_index_data = 4'h0, dev_line = 4'h0;
  logic [3:0]  dev_reg = 4'h0, scan_line, scan_transitions, secondary_select;
  logic [3:0]  secondary_address;
  logic        clear_all_lines = 0, scan_enable = 0, scan_clear = 0;
  logic        done_clear = 0, lmr_wr_en = 0, sec_select_wr = 0, hit;
  logic        sec_address_wr = 0, sec_data_wr = 0, dev_wr_en = 0;
  logic        scan_done_set, dev_wr_grant;
  logic [7:0]  lmr_wr_data = 8'h00, lmr_rd_data, v, c;
  logic [15:0] sec_wr_data = 16'h0000, dev_wr_data = 16'h0000, sec_rd_data;
  logic [15:0] dev_rd_data, terminal_ready, request_to_send, new_sync;
  logic [15:0] secondary_transmit, carrier_cmd = '0, ring_cmd = '0;
  logic [15:0] modem_dsr_secondary_receive, modem_cts, modem_carrier, modem_ring;
  logic [15:0] e_tr, e_rts, e_ns;
  int          err_count = 0, checks = 0, cyc = 0;

  always #2.5 sys_clk = ~sys_clk;

  mlcs_top #(.LINES(16)) uut (.sys_clk, .rst_n, .line_select, .clear_all_lines,
    .scan_enable, .scan_clear, .done_clear, .scan_done_set, .scan_line,
    .scan_transitions, .lmr_wr_en, .lmr_wr_data, .lmr_rd_data, .sync_mode_pin,
    .modem_dsr_secondary_receive, .modem_cts, .modem_carrier, .modem_ring, .terminal_ready,
    .request_to_send, .new_sync, .secondary_transmit, .sec_select_wr,
    .sec_address_wr, .sec_index_data, .sec_data_wr, .sec_wr_data, .sec_rd_data,
    .secondary_select, .secondary_address, .dev_wr_en, .dev_wr_grant, .dev_line,
    .dev_reg, .dev_wr_data, .dev_rd_data);
  mlcs_modem_model #(.LINES(16), .DELAY(4)) u_modem (.sys_clk, .terminal_ready,
    .request_to_send, .carrier_cmd, .ring_cmd, .modem_dsr_secondary_receive, .modem_cts,
    .modem_carrier, .modem_ring);

  task automatic close_out;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic check(input string name, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", name, e, g);
      err_count++;
    end
  endtask : check

  task automatic lmr_write(input logic [3:0] l, input logic [7:0] d);
    @(posedge sys_clk);
    line_select <= l; lmr_wr_en <= 1'b1; lmr_wr_data <= d;
    @(posedge sys_clk);
    lmr_wr_en <= 1'b0;
  endtask : lmr_write

  task automatic lmr_read(input logic [3:0] l, output logic [7:0] d);
    @(posedge sys_clk);
    line_select <= l;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    d = lmr_rd_data;
  endtask : lmr_read

  task automatic sec_load(input logic [3:0] s, input logic [3:0] a);
    @(posedge sys_clk);
    sec_select_wr <= 1'b1; sec_index_data <= s;
    @(posedge sys_clk);
    sec_select_wr <= 1'b0; sec_address_wr <= 1'b1; sec_index_data <= a;
    @(posedge sys_clk);
    sec_address_wr <= 1'b0;
  endtask : sec_load

  task automatic sec_write(input logic [3:0] s, input logic [3:0] a, input logic [15:0] d);
    sec_load(s, a);
    sec_data_wr <= 1'b1; sec_wr_data <= d;
    @(posedge sys_clk);
    sec_data_wr <= 1'b0;
  endtask : sec_write

  task automatic sec_check(input logic [3:0] s, input logic [3:0] a, input logic [15:0] d);
    sec_load(s, a);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    check("secondary_select", 16'(s), 16'(secondary_select));
    check("secondary_address", 16'(a), 16'(secondary_address));
    check("sec_rd_data", d, sec_rd_data);
  endtask : sec_check

  task automatic wait_done(input int n, output logic h);
    h = 1'b0;
    for (int k = 0; k < n && !h; k++) begin
      @(negedge sys_clk);
      if (scan_done_set === 1'b1) h = 1'b1;
    end
  endtask : wait_done

  task automatic pulse_clear;
    @(posedge sys_clk);
    clear_all_lines <= 1'b1;
    @(posedge sys_clk);
    clear_all_lines <= 1'b0;
  endtask : pulse_clear

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check("lmr_rd_data", 16'h0, 16'(lmr_rd_data));
    for (int i = 0; i < 16; i++) begin
      c = 8'(i) ^ 8'h06;
      {e_ns[i], e_rts[i], e_tr[i]} = c[3:1];
      lmr_write(4'(i), {4'hf, c[3:0]});
    end
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    check("terminal_ready", e_tr, terminal_ready);
    check("request_to_send", e_rts, request_to_send);
    check("new_sync", e_ns, new_sync);
    check("secondary_transmit", 16'h0, secondary_transmit);
    for (int i = 0; i < 16; i++) begin
      c = 8'(i) ^ 8'h06;
      lmr_read(4'(i), v);
      if (c[0]) c[5:4] = c[2:1];
      check("lmr_rd_data", 16'(c), 16'(v));
    end
    pulse_clear();
    lmr_read(4'h5, v);
    check("lmr_rd_data", 16'h0, 16'(v));
    check("terminal_ready", 16'h0, terminal_ready | request_to_send | new_sync);
    @(posedge sys_clk);
    scan_clear <= 1'b1;
    @(posedge sys_clk);
    scan_clear <= 1'b0;
    lmr_write(4'h3, 8'h07);
    lmr_write(4'h4, 8'h06);
    carrier_cmd <= 16'h0018; ring_cmd <= 16'h0018;
    repeat (20) @(posedge sys_clk);
    lmr_read(4'h3, v);
    check("lmr_rd_data", 16'h00f7, 16'(v));
    lmr_read(4'h4, v);
    check("lmr_rd_data", 16'h0006, 16'(v));
    @(posedge sys_clk);
    scan_enable <= 1'b1;
    wait_done(200, hit);
    check("scan_done_set", 16'h1, 16'(hit));
    check("scan_line", 16'h3, 16'(scan_line));
    check("scan_transitions", 16'hf, 16'(scan_transitions));
    @(posedge sys_clk);
    done_clear <= 1'b1; ring_cmd <= 16'h0010;
    @(posedge sys_clk);
    done_clear <= 1'b0;
    wait_done(60, hit);
    check("scan_done_set", 16'h0, 16'(hit));
    carrier_cmd <= 16'h0010;
    wait_done(200, hit);
    check("scan_transitions", 16'h4, 16'(scan_transitions));
    @(posedge sys_clk);
    scan_enable <= 1'b0;
    sec_write(4'h3, 4'h5, 16'hbeef);
    sec_write(4'hf, 4'hf, 16'h1234);
    sec_check(4'h3, 4'h5, 16'hbeef);
    sec_check(4'hf, 4'hf, 16'h1234);
    @(posedge sys_clk);
    dev_wr_en <= 1'b1; dev_wr_data <= 16'h5a5a;
    @(negedge sys_clk);
    check("dev_wr_grant", 16'h1, 16'(dev_wr_grant));
    @(posedge sys_clk);
    dev_wr_en <= 1'b0;
    sec_load(4'h0, 4'h0);
    sec_data_wr <= 1'b1; sec_wr_data <= 16'ha5a5;
    dev_wr_en <= 1'b1; dev_wr_data <= 16'h0f0f;
    @(negedge sys_clk);
    check("dev_wr_grant", 16'h0, 16'(dev_wr_grant));
    @(posedge sys_clk);
    sec_data_wr <= 1'b0; dev_wr_en <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check("dev_rd_data", 16'ha5a5, dev_rd_data);
    @(posedge sys_clk);
    rst_n <= 1'b0; sync_mode_pin <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check("terminal_ready", 16'h0, terminal_ready);
    sec_check(4'h3, 4'h5, 16'hbeef);
    lmr_write(4'h2, 8'h08);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check("secondary_transmit", 16'h0004, secondary_transmit);
    check("new_sync", 16'h0, new_sync);
    lmr_write(4'h2, 8'h03);
    repeat (4) @(posedge sys_clk);
    lmr_read(4'h2, v);
    check("lmr_rd_data", 16'h0013, 16'(v));
    close_out();
  end
endmodule : test_mlcs_top

bind mlcs_top mlcs_props #(.LINES(LINES)) u_props (.sys_clk(sys_clk), .rst_n(rst_n),
  .line_select(line_select), .clear_all_lines(clear_all_lines),
  .lmr_wr_en(lmr_wr_en), .lmr_wr_data(lmr_wr_data), .lmr_rd_data(lmr_rd_data),
  .terminal_ready(terminal_ready), .request_to_send(request_to_send),
  .new_sync(new_sync), .secondary_transmit(secondary_transmit),
  .scan_done_set(scan_done_set), .scan_transitions(scan_transitions),
  .sec_select_wr(sec_select_wr), .sec_address_wr(sec_address_wr),
  .sec_data_wr(sec_data_wr), .sec_wr_data(sec_wr_data), .sec_rd_data(sec_rd_data),
  .dev_wr_en(dev_wr_en), .dev_wr_grant(dev_wr_grant));
`default_nettype wire
